// file: testbench/ctl.sv
`timescale 1ns/1ps
module ctl(input wire clk, output reg serialDataLine = 1'h0,
    output reg linkClockLine = 1'h0, output reg selectEnableLine = 1'h0);
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // stop drops both lines before the latch pulse, an aborted cycle
    task send(input [23:0] bits, input stop);
        integer i;
        {linkClockLine, selectEnableLine} = 2'h3;
        tick(4);
        for (i = 0; i < 24; i++)
        begin
            linkClockLine = 1'h0;
            tick(1);
            serialDataLine = bits[i];
            tick(3);
            linkClockLine = 1'h1;
            tick(4);
        end
        // inverted after release so a stale bit cannot pass for data
        serialDataLine = ~serialDataLine;
        {linkClockLine, selectEnableLine} = {!stop, 1'h0};
        tick(8);
        selectEnableLine = !stop;
        tick(8);
        {linkClockLine, selectEnableLine} = 2'h0;
        tick(8);
    endtask
    // drops both lines after n bits, a cycle cut short mid-field
    task cut(input [23:0] bits, input integer n);
        integer i;
        {linkClockLine, selectEnableLine} = 2'h3;
        tick(4);
        for (i = 0; i < n; i++)
        begin
            linkClockLine = 1'h0;
            tick(1);
            serialDataLine = bits[i];
            tick(3);
            linkClockLine = 1'h1;
            tick(4);
        end
        {linkClockLine, selectEnableLine} = 2'h0;
        tick(8);
    endtask
endmodule

// file: testbench/relay_monitor.sv
`timescale 1ns/1ps
module relay_monitor(input wire clk, input wire resetn,
    input wire linkClockLine, input wire selectEnableLine,
    input wire [1:0] switchA, input wire [1:0] switchB,
    input wire [15:0] relayOut);
    wire en = selectEnableLine;
    wire lk = linkClockLine;
    wire [15:0] r = relayOut;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_reset_clear: assert property ($rose(resetn) |-> !r)
        else $error("not cleared");
    chk_en_low: assert property (!en [*8] |=> $stable(r))
        else $error("moved idle");
    chk_clk_low: assert property (!lk [*8] |=> $stable(r))
        else $error("moved clock low");
    chk_shift_quiet: assert property (en [*8] |=> $stable(r))
        else $error("moved shifting");
    chk_latch_cause: assert property ($changed(r) && $past(resetn)
        |-> $past(lk, 6) && !$past(en, 8)) else $error("bad latch");
    chk_latch_hold: assert property ($changed(r) |=> $stable(r) [*3])
        else $error("no hold");
    chk_no_bcast: assert property (&{switchA, switchB} |=> $stable(r))
        else $error("unit 15");
    chk_end_quiet: assert property ($fell(en) && !lk |=> $stable(r) [*8])
        else $error("moved at end");
    cover property ($changed(r));
    cover property ($fell(en) && lk);
    cover property (&{switchA, switchB} && en);
endmodule
bind addressed_relay_shift_latch relay_monitor relay_monitor_i(.*);

// file: testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) checks++; if ((a) !== (b)) \
    begin n_errors++; $display("mismatch %0t %h", $time, a); end
module tb;
    reg clk = 1'h0, resetn = 1'h0;
    reg [1:0] switchA = 2'h1, switchB = 2'h1;
    wire serialDataLine, linkClockLine, selectEnableLine;
    wire [15:0] relayOut;
    integer n_errors = 0, checks = 0, cycles = 0;
    ctl ctl_i(.*);
    addressed_relay_shift_latch addressed_relay_shift_latch_i(.*);
    initial forever #25 clk = ~clk;
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
        if (++cycles == 3000)
        begin
            n_errors++;
            end_sim;
        end
    task test_reset;
        ctl_i.tick(3);
        resetn = 1'h1;
        ctl_i.tick(4);
        `CHK(relayOut, 16'h0000)
        $display("test reset done");
    endtask
    task test_match;
        ctl_i.send(24'hA5C305, 1'h0);
        `CHK(relayOut, 16'hA5C3)
        $display("test match done");
    endtask
    task test_foreign;
        ctl_i.send(24'hFFFF06, 1'h0);
        `CHK(relayOut, 16'hA5C3)
        $display("test foreign done");
    endtask
    task test_abort;
        ctl_i.send(24'h123405, 1'h1);
        `CHK(relayOut, 16'hA5C3)
        $display("test abort done");
    endtask
    task test_cut;
        ctl_i.cut(24'h5AAA05, 12);
        `CHK(relayOut, 16'hA5C3)
        $display("test cut done");
    endtask
    task test_single;
        ctl_i.send(24'h000105, 1'h0);
        `CHK(relayOut, 16'h0001)
        $display("test single done");
    endtask
    task test_other_unit;
        switchB = 2'h2;
        ctl_i.send(24'h800009, 1'h0);
        `CHK(relayOut, 16'h8000)
        $display("test other unit done");
    endtask
    task test_broadcast;
        switchA = 2'h3;
        switchB = 2'h3;
        ctl_i.send(24'hFFFF0F, 1'h0);
        `CHK(relayOut, 16'h8000)
        $display("test broadcast done");
    endtask
    initial
    begin
        test_reset;
        test_match;
        test_foreign;
        test_abort;
        test_cut;
        test_single;
        test_other_unit;
        test_broadcast;
        end_sim;
    end
endmodule

// file: verilog/addressed_relay_shift_latch.v
`timescale 1ns/1ps
`include "relay_link_map.vh"
module addressed_relay_shift_latch
#(
    parameter ADDR_W = `ADDR_BITS,
    parameter CHAN_W = `CHAN_BITS,
    parameter CNT_W = `CNT_BITS,
    parameter SEL_W = 2
)
(
    input wire clk,
    input wire resetn,
    input wire serialDataLine,
    input wire linkClockLine,
    input wire selectEnableLine,
    input wire [SEL_W-1:0] switchA,
    input wire [SEL_W-1:0] switchB,
    output reg [CHAN_W-1:0] relayOut
);
// ************************************************************
// state codes
// ************************************************************
localparam IDLE = 2'b00;
localparam ADDR = 2'b01;
localparam DATA = 2'b10;
localparam DONE = 2'b11;

// ************************************************************
// input synchronisers
// ************************************************************
reg [2:0] sync1_reg;
reg [2:0] sync2_reg;
reg clkPrev_reg;
reg enPrev_reg;
reg [1:0] state_reg;
reg [CNT_W-1:0] count_reg;
reg [ADDR_W-1:0] addr_reg;
reg [CHAN_W-1:0] shift_reg;
reg selected_reg;
reg armed_reg;
// selector straps get their own two stages; ownAddr_reg is the second
// and the only one that the comparator reads
reg [2*SEL_W-1:0] switchSync1_reg;
reg [2*SEL_W-1:0] ownAddr_reg;
wire dataS;
wire clkS;
wire enS;
wire clkRise;
wire enFall;
wire enRise;

// ************************************************************
// link edge detection
// ************************************************************
// each link phase must last at least one clock or an edge is lost
assign dataS = sync2_reg[0];
assign clkS = sync2_reg[1];
assign enS = sync2_reg[2];
assign clkRise = clkS & ~clkPrev_reg;
assign enFall = ~enS & enPrev_reg;
assign enRise = enS & ~enPrev_reg;

always @(posedge clk)
begin
    if (!resetn)
    begin
        sync1_reg <= 3'h0;
        sync2_reg <= 3'h0;
        clkPrev_reg <= 1'b0;
        enPrev_reg <= 1'b0;
    end
    else
    begin
        sync1_reg <= {selectEnableLine, linkClockLine, serialDataLine};
        sync2_reg <= sync1_reg;
        clkPrev_reg <= clkS;
        enPrev_reg <= enS;
    end
end

// ************************************************************
// address selector synchroniser
// ************************************************************
// straps may be turned while powered; two stages keep a
// metastable value away from the comparator
always @(posedge clk)
begin
    if (!resetn)
    begin
        switchSync1_reg <= {(2*SEL_W){1'b0}};
        ownAddr_reg <= {(2*SEL_W){1'b0}};
    end
    else
    begin
        switchSync1_reg <= {switchB, switchA};
        ownAddr_reg <= switchSync1_reg; // [RL10]
    end
end

// ************************************************************
// shift and address helpers
// ************************************************************
// both fields arrive lsb first, so each new bit enters at the top
// and the first bit of the field ends in bit 0
function [ADDR_W-1:0] shiftAddr;
    input [ADDR_W-1:0] cur;
    input bitIn;
    begin
        shiftAddr = {bitIn, cur[ADDR_W-1:1]};
    end
endfunction

function [CHAN_W-1:0] shiftChan;
    input [CHAN_W-1:0] cur;
    input bitIn;
    begin
        shiftChan = {bitIn, cur[CHAN_W-1:1]};
    end
endfunction

// unit address 15 is broadcast, never a match
function addrMatch;
    input [ADDR_W-1:0] rx;
    input [2*SEL_W-1:0] own;
    begin
        addrMatch = (own != `BROADCAST_ADDR) &&
            (rx == {{(ADDR_W-2*SEL_W){1'b0}}, own});
    end
endfunction

localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
wire [ADDR_W-1:0] addrNext;
wire [CHAN_W-1:0] chanNext;
assign addrNext = shiftAddr(addr_reg, dataS);
assign chanNext = shiftChan(shift_reg, dataS);

// ************************************************************
// cycle sequencer
// ************************************************************
always @(posedge clk)
begin
    if (!resetn)
    begin
        state_reg <= IDLE;
        count_reg <= {CNT_W{1'b0}};
        addr_reg <= {ADDR_W{1'b0}};
        shift_reg <= {CHAN_W{1'b0}};
        selected_reg <= 1'b0;
        armed_reg <= 1'b0;
        relayOut <= `OUTPUTS_RESET; // [RL12]
    end
    else
    begin
        case (state_reg)
            IDLE:
            begin
                // wait for both lines low first so a stuck-high bus
                // cannot restart a cycle every clock
                if (!clkS && !enS)
                    armed_reg <= 1'b1;
                if (armed_reg && clkS && enS)
                begin
                    state_reg <= ADDR; // [RL1]
                    count_reg <= {CNT_W{1'b0}};
                    selected_reg <= 1'b0;
                    armed_reg <= 1'b0;
                end
            end
            ADDR:
            begin
                // enable dropping mid-address abandons the cycle
                if (!enS)
                    state_reg <= IDLE; // [RL12]
                else if (clkRise)
                begin
                    addr_reg <= addrNext; // [RL4]
                    if (count_reg == ADDR_W - 1) // [RL5]
                    begin
                        count_reg <= {CNT_W{1'b0}};
                        state_reg <= DATA;
                        // a foreign unit still counts the data bits
                        // but never reaches its latch
                        selected_reg <=
                            addrMatch(addrNext, ownAddr_reg); // [RL6] [RL10]
                    end
                    else
                        count_reg <= count_reg + CNT_ONE;
                end
            end
            DATA:
            begin
                if (!enS)
                    state_reg <= IDLE; // [RL12]
                else if (clkRise)
                begin
                    // lsb-first: first bit ends in bit 0, channel 1
                    shift_reg <= chanNext; // [RL7]
                    if (count_reg == CHAN_W - 1)
                        state_reg <= DONE;
                    count_reg <= count_reg + CNT_ONE;
                end
            end
            DONE:
            begin
                // clock must stay high across the latch pulse; a drop
                // here is a cut cycle, and waiting on would let the
                // next cycle start pass for the latch edge
                if (!clkS)
                    state_reg <= IDLE; // [RL12]
                else if (enRise)
                begin
                    if (selected_reg)
                        relayOut <= shift_reg; // [RL8] [RL11]
                    state_reg <= IDLE; // [RL9]
                end
            end
            default:
                state_reg <= IDLE;
        endcase
    end
end
endmodule

// file: verilog/relay_link_map.vh
// Contract
// [RL1] clock and enable both high together start a new transfer cycle.
// [RL2] controller holds enable high, toggles clock, drives serial data.
// [RL3] controller changes data after falling clock edges, fields LSB first.
// [RL4] device samples data on each rising link clock edge into shift register.
// [RL5] first eight bits of a cycle are the target address.
// [RL6] device selected only when address matches its own; else ignores cycle.
// [RL7] next sixteen bits go to channels one upward, first bit channel one.
// [RL8] with clock high, enable pulsed low then high latches shifted bits.
// [RL9] after latch pulse controller lowers enable and clock to end cycle.
// [RL10] own address is A plus four times B; fifteen is never a unit.
// [RL11] outputs hold latched state until a later addressed cycle changes them.
// [RL12] reset clears outputs; foreign or aborted cycles leave them unchanged.
`ifndef RELAY_LINK_MAP_VH
`define RELAY_LINK_MAP_VH
`define ADDR_BITS 8
`define CHAN_BITS 16
`define CNT_BITS 5
`define BROADCAST_ADDR 4'hF
`define OUTPUTS_RESET 16'h0000
`endif
